// ---- urset_top.sv ----
// serial port register bank with reset state and event timing
`timescale 1ns/100ps
module urset_top (
   input  wire logic       ref_clk,
   input  wire logic       nrst,
   input  wire logic       host_select_n,
   input  wire logic [2:0] host_addr,
   input  wire logic       host_read_strobe_n,
   input  wire logic       host_write_strobe_n,
   input  wire logic [7:0] host_data_in,
   output logic [7:0]      host_data_out,
   output logic            host_data_oe,
   input  wire logic       serial_in,
   output logic            serial_out,
   input  wire logic       cts_n,
   input  wire logic       dsr_n,
   input  wire logic       ri_n,
   input  wire logic       cd_n,
   output logic            dtr_n,
   output logic            rts_n,
   output logic            op1_n,
   output logic            op2_n,
   output logic            irq,
   output logic            receive_ready_n,
   output logic            transmit_ready_n
);
   typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} urset_rx_e;
   typedef enum logic [1:0] {TX_IDLE, TX_WAIT, TX_SHIFT} urset_tx_e;

   function automatic logic [19:0] bit_period(input logic [15:0] dv);
      bit_period = {dv, 4'h0} - 20'h00001;
   endfunction : bit_period

   function automatic logic [7:0] isrc_of(input logic [7:0] ien, input logic lse,
                                          input logic dr, input logic thre, input logic msd);
      if (ien[urset_pkg::IEN_LS] && lse)
         isrc_of = urset_pkg::ISRC_LS;
      else if (ien[urset_pkg::IEN_RX] && dr)
         isrc_of = urset_pkg::ISRC_RX;
      else if (ien[urset_pkg::IEN_THRE] && thre)
         isrc_of = urset_pkg::ISRC_THRE;
      else if (ien[urset_pkg::IEN_MS] && msd)
         isrc_of = urset_pkg::ISRC_MS;
      else
         isrc_of = urset_pkg::ISRC_NONE;
   endfunction : isrc_of

   urset_pkg::urset_pins_s pin_raw;
   urset_pkg::urset_pins_s sync1_r;
   urset_pkg::urset_pins_s sync2_r;

   logic [7:0]  ien_r, ien_nxt, lcr_r, lcr_nxt, mcr_r, mcr_nxt, qcr_r, qcr_nxt;
   logic [7:0]  scr_r, scr_nxt, rbr_r, rbr_nxt, dout_r, dout_nxt;
   logic [15:0] div_r, div_nxt;
   logic        doe_r, doe_nxt, rd_prev_r, rd_prev_nxt, wr_prev_r, wr_prev_nxt;
   logic        dr_r, dr_nxt, thre_int_r, thre_int_nxt, thre_prev_r, thre_prev_nxt;
   logic        irq_r, irq_nxt, receive_ready_n_n_r, receive_ready_n_n_nxt, transmit_ready_n_n_r, transmit_ready_n_n_nxt;
   logic        sout_r, sout_nxt;
   logic [3:0]  msd_r, msd_nxt, msl_prev_r, mout_n_r, mout_n_nxt;
   urset_pkg::urset_lserr_s lse_r, lse_nxt;

   logic        rd_act, wr_act, rd_go, wr_go, dlab, loop, rx_in;
   logic [3:0]  msl;
   logic [7:0]  lsr_val, isrc_val;
   logic        buf_in_valid, buf_in_ready, buf_out_valid, tx_take, buf_flush;
   logic [7:0]  buf_out_data;

   urset_rx_e   rx_st_r, rx_st_nxt;
   logic [19:0] rx_cnt_r, rx_cnt_nxt;
   logic [2:0]  rx_bit_r, rx_bit_nxt;
   logic [7:0]  rx_sh_r, rx_sh_nxt;
   logic        rx_done;

   urset_tx_e   tx_st_r, tx_st_nxt;
   logic [19:0] tx_cnt_r, tx_cnt_nxt;
   logic [3:0]  tx_bit_r, tx_bit_nxt;
   logic [9:0]  tx_sh_r, tx_sh_nxt;
   logic        tx_line_r, tx_line_nxt;

   assign pin_raw = '{cs_n: host_select_n, rd_n: host_read_strobe_n,
                      wr_n: host_write_strobe_n, adr: host_addr, dat: host_data_in,
                      sin: serial_in, mdm_n: {cd_n, ri_n, dsr_n, cts_n}};

   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         sync1_r <= '1;
         sync2_r <= '1;
      end
      else
      begin
         sync1_r <= pin_raw;
         sync2_r <= sync1_r;
      end
   end

   urset_buf #(.W(8), .DEPTH(2)) u_txbuf (
      .clk       (ref_clk),
      .rst_n     (nrst),
      .flush     (buf_flush),
      .in_data   (sync2_r.dat),
      .in_valid  (buf_in_valid),
      .in_ready  (buf_in_ready),
      .out_data  (buf_out_data),
      .out_valid (buf_out_valid),
      .out_ready (tx_take)
   );

   // receiver: half-bit start check, then mid-bit sampling at 16 x divisor
   always_comb
   begin
      rx_st_nxt  = rx_st_r;
      rx_cnt_nxt = rx_cnt_r;
      rx_bit_nxt = rx_bit_r;
      rx_sh_nxt  = rx_sh_r;
      rx_done    = 1'b0;
      if (rx_cnt_r != '0)
         rx_cnt_nxt = rx_cnt_r - 20'h00001;
      else
         case (rx_st_r)
            RX_IDLE:
               if (!rx_in)
               begin
                  rx_st_nxt  = RX_START;
                  rx_cnt_nxt = bit_period(div_r) >> 1;
               end
            RX_START:
            begin
               rx_st_nxt  = rx_in ? RX_IDLE : RX_DATA;
               rx_cnt_nxt = bit_period(div_r);
               rx_bit_nxt = 3'h0;
            end
            RX_DATA:
            begin
               rx_sh_nxt  = {rx_in, rx_sh_r[7:1]};
               rx_cnt_nxt = bit_period(div_r);
               rx_bit_nxt = rx_bit_r + 3'h1;
               if (rx_bit_r == 3'h7)
                  rx_st_nxt = RX_STOP;
            end
            RX_STOP:
            begin
               rx_done   = 1'b1;
               rx_st_nxt = RX_IDLE;
            end
            default: rx_st_nxt = RX_IDLE;
         endcase
   end

   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         rx_st_r  <= RX_IDLE;
         rx_cnt_r <= '0;
         rx_bit_r <= '0;
         rx_sh_r  <= '0;
      end
      else
      begin
         rx_st_r  <= rx_st_nxt;
         rx_cnt_r <= rx_cnt_nxt;
         rx_bit_r <= rx_bit_nxt;
         rx_sh_r  <= rx_sh_nxt;
      end
   end

   // transmitter: fixed lead-in after taking a word, then start, 8 data, stop
   always_comb
   begin
      tx_st_nxt   = tx_st_r;
      tx_cnt_nxt  = tx_cnt_r;
      tx_bit_nxt  = tx_bit_r;
      tx_sh_nxt   = tx_sh_r;
      tx_line_nxt = tx_line_r;
      tx_take     = (tx_st_r == TX_IDLE);
      if (tx_st_r != TX_IDLE && tx_cnt_r != '0)
         tx_cnt_nxt = tx_cnt_r - 20'h00001;
      else
         case (tx_st_r)
            TX_IDLE:
               if (buf_out_valid)
               begin
                  tx_st_nxt  = TX_WAIT;
                  tx_cnt_nxt = 20'(urset_pkg::TX_START_CYC - 1);
                  tx_sh_nxt  = {1'b1, buf_out_data, 1'b0};
               end
            TX_WAIT, TX_SHIFT:
            begin
               tx_cnt_nxt = bit_period(div_r);
               if (tx_st_r == TX_SHIFT && tx_bit_r == 4'h9)
               begin
                  tx_st_nxt   = TX_IDLE;
                  tx_line_nxt = 1'b1;
               end
               else
               begin
                  tx_line_nxt = tx_sh_r[0];
                  tx_sh_nxt   = {1'b1, tx_sh_r[9:1]};
                  tx_bit_nxt  = (tx_st_r == TX_WAIT) ? 4'h0 : tx_bit_r + 4'h1;
                  tx_st_nxt   = TX_SHIFT;
               end
            end
            default: tx_st_nxt = TX_IDLE;
         endcase
   end

   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         tx_st_r   <= TX_IDLE;
         tx_cnt_r  <= '0;
         tx_bit_r  <= '0;
         tx_sh_r   <= '1;
         tx_line_r <= 1'b1;
      end
      else
      begin
         tx_st_r   <= tx_st_nxt;
         tx_cnt_r  <= tx_cnt_nxt;
         tx_bit_r  <= tx_bit_nxt;
         tx_sh_r   <= tx_sh_nxt;
         tx_line_r <= tx_line_nxt;
      end
   end

   // host side: strobe edges, register file, status and pin outputs
   always_comb
   begin
      dlab   = lcr_r[urset_pkg::LCTL_DLAB];
      loop   = mcr_r[urset_pkg::MCTL_LOOP];
      rx_in  = loop ? tx_line_r : sync2_r.sin;
      msl    = loop ? {mcr_r[3], mcr_r[2], mcr_r[0], mcr_r[1]} : ~sync2_r.mdm_n;
      rd_act = !sync2_r.cs_n && !sync2_r.rd_n;
      wr_act = !sync2_r.cs_n && !sync2_r.wr_n;
      rd_go  = rd_act && !rd_prev_r;
      wr_go  = wr_act && !wr_prev_r;
      lsr_val = {lse_r.brk | lse_r.frm, !buf_out_valid && tx_st_r == TX_IDLE,
                 !buf_out_valid, lse_r.brk, lse_r.frm, 1'b0, lse_r.ovr, dr_r};
      isrc_val = isrc_of(ien_r, |lse_r, dr_r, thre_int_r, |msd_r);
      rd_prev_nxt = rd_act;
      wr_prev_nxt = wr_act;
      doe_nxt  = rd_act;
      dout_nxt = dout_r;
      ien_nxt = ien_r;
      lcr_nxt = lcr_r;
      mcr_nxt = mcr_r;
      qcr_nxt = qcr_r;
      scr_nxt = scr_r;
      div_nxt = div_r;
      rbr_nxt = rbr_r;
      dr_nxt  = dr_r;
      lse_nxt = lse_r;
      msd_nxt = msd_r;
      thre_int_nxt  = thre_int_r;
      thre_prev_nxt = !buf_out_valid;
      buf_flush     = 1'b0;
      buf_in_valid  = wr_go && sync2_r.adr == urset_pkg::ADR_DATA && !dlab;
      if (rd_go)
         case (sync2_r.adr)
            urset_pkg::ADR_DATA:
            begin
               dout_nxt = dlab ? div_r[7:0] : rbr_r;
               if (!dlab)
                  dr_nxt = 1'b0;
            end
            urset_pkg::ADR_IEN:  dout_nxt = dlab ? div_r[15:8] : ien_r;
            urset_pkg::ADR_ISRC:
            begin
               dout_nxt = isrc_val;
               if (isrc_val == urset_pkg::ISRC_THRE)
                  thre_int_nxt = 1'b0;
            end
            urset_pkg::ADR_LCTL: dout_nxt = lcr_r;
            urset_pkg::ADR_MCTL: dout_nxt = mcr_r;
            urset_pkg::ADR_LSTAT:
            begin
               dout_nxt = lsr_val;
               lse_nxt  = '0;
            end
            urset_pkg::ADR_MSTAT:
            begin
               dout_nxt = {msl, msd_r};
               msd_nxt  = 4'h0;
            end
            default: dout_nxt = scr_r;
         endcase
      if (wr_go)
         case (sync2_r.adr)
            urset_pkg::ADR_DATA:
               if (dlab)
                  div_nxt[7:0] = sync2_r.dat;
               else
                  thre_int_nxt = 1'b0;
            urset_pkg::ADR_IEN:
               if (dlab)
                  div_nxt[15:8] = sync2_r.dat;
               else
                  ien_nxt = sync2_r.dat;
            urset_pkg::ADR_ISRC:
            begin
               qcr_nxt   = sync2_r.dat;
               buf_flush = sync2_r.dat[urset_pkg::QCTL_TXRST];
               if (sync2_r.dat[urset_pkg::QCTL_RXRST])
                  dr_nxt = 1'b0;
            end
            urset_pkg::ADR_LCTL: lcr_nxt = sync2_r.dat;
            urset_pkg::ADR_MCTL: mcr_nxt = {3'h0, sync2_r.dat[4:0]};
            urset_pkg::ADR_SCR:  scr_nxt = sync2_r.dat;
            default: scr_nxt = scr_r;
         endcase
      // hardware events after the clears so that a set in the same cycle wins
      if (rx_done)
      begin
         rbr_nxt = rx_sh_r;
         dr_nxt  = 1'b1;
         lse_nxt.ovr = lse_nxt.ovr | dr_r;
         lse_nxt.frm = lse_nxt.frm | !rx_in;
         lse_nxt.brk = lse_nxt.brk | (!rx_in && rx_sh_r == 8'h00);
      end
      if (!buf_out_valid && !thre_prev_r)
         thre_int_nxt = 1'b1;
      msd_nxt[0] = msd_nxt[0] | (msl[0] ^ msl_prev_r[0]);
      msd_nxt[1] = msd_nxt[1] | (msl[1] ^ msl_prev_r[1]);
      msd_nxt[2] = msd_nxt[2] | (!msl[2] && msl_prev_r[2]);
      msd_nxt[3] = msd_nxt[3] | (msl[3] ^ msl_prev_r[3]);
      irq_nxt     = isrc_of(ien_nxt, |lse_nxt, dr_nxt, thre_int_nxt, |msd_nxt) !=
                    urset_pkg::ISRC_NONE;
      receive_ready_n_n_nxt = !dr_nxt;
      transmit_ready_n_n_nxt = !buf_in_ready || (buf_in_valid && !buf_out_valid && !tx_take);
      mout_n_nxt  = mcr_nxt[urset_pkg::MCTL_LOOP] ? 4'hF : ~mcr_nxt[3:0];
      sout_nxt    = mcr_nxt[urset_pkg::MCTL_LOOP] ? 1'b1 :
                    (!lcr_nxt[urset_pkg::LCTL_BRK] && tx_line_nxt);
   end

   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         ien_r <= urset_pkg::IEN_RST;
         lcr_r <= urset_pkg::LCTL_RST;
         mcr_r <= urset_pkg::MCTL_RST;
         qcr_r <= urset_pkg::QCTL_RST;
         scr_r <= 8'h00;
         div_r <= urset_pkg::DIV_RST;
         rbr_r <= 8'h00;
         dr_r  <= 1'b0;
         lse_r <= '0;
         msd_r <= 4'h0;
         msl_prev_r  <= 4'h0;
         thre_int_r  <= 1'b0;
         thre_prev_r <= 1'b1;
         rd_prev_r <= 1'b0;
         wr_prev_r <= 1'b0;
         dout_r    <= 8'h00;
         doe_r     <= 1'b0;
         irq_r     <= 1'b0;
         receive_ready_n_n_r <= 1'b1;
         transmit_ready_n_n_r <= 1'b0;
         mout_n_r  <= 4'hF;
         sout_r    <= 1'b1;
      end
      else
      begin
         ien_r <= ien_nxt;
         lcr_r <= lcr_nxt;
         mcr_r <= mcr_nxt;
         qcr_r <= qcr_nxt;
         scr_r <= scr_nxt;
         div_r <= div_nxt;
         rbr_r <= rbr_nxt;
         dr_r  <= dr_nxt;
         lse_r <= lse_nxt;
         msd_r <= msd_nxt;
         msl_prev_r  <= msl;
         thre_int_r  <= thre_int_nxt;
         thre_prev_r <= thre_prev_nxt;
         rd_prev_r <= rd_prev_nxt;
         wr_prev_r <= wr_prev_nxt;
         dout_r    <= dout_nxt;
         doe_r     <= doe_nxt;
         irq_r     <= irq_nxt;
         receive_ready_n_n_r <= receive_ready_n_n_nxt;
         transmit_ready_n_n_r <= transmit_ready_n_n_nxt;
         mout_n_r  <= mout_n_nxt;
         sout_r    <= sout_nxt;
      end
   end

   assign host_data_out    = dout_r;
   assign host_data_oe     = doe_r;
   assign serial_out       = sout_r;
   assign {op2_n, op1_n, rts_n, dtr_n} = mout_n_r;
   assign irq              = irq_r;
   assign receive_ready_n  = receive_ready_n_n_r;
   assign transmit_ready_n = transmit_ready_n_n_r;

   a_scr_readback: assert property (@(posedge ref_clk) disable iff (!nrst)
      (wr_go && sync2_r.adr == urset_pkg::ADR_SCR) |=> (scr_r == $past(sync2_r.dat)))
      else $error("scratch register lost the written value");
   a_ien_reset: assert property (@(posedge ref_clk)
      $rose(nrst) |-> (ien_r == 8'h00))
      else $error("interrupt enable not clear after reset");
   a_isrc_idle: assert property (@(posedge ref_clk) disable iff (!nrst)
      (!dr_r && !thre_int_r && lse_r == '0 && msd_r == 4'h0) |-> (isrc_val == 8'h01))
      else $error("interrupt source not idle with nothing pending");
   a_lsr_reset: assert property (@(posedge ref_clk)
      $rose(nrst) |-> (lsr_val == 8'h60))
      else $error("line status wrong after reset");
   a_msr_levels: assert property (@(posedge ref_clk) disable iff (!nrst)
      !mcr_r[4] |-> (msl == ~sync2_r.mdm_n))
      else $error("modem status levels do not follow the pins");
   a_rx_irq_time: assert property (@(posedge ref_clk) disable iff (!nrst)
      (rx_done && ien_r[0]) |=> irq_r)
      else $error("receive interrupt late");
   a_rx_ready_time: assert property (@(posedge ref_clk) disable iff (!nrst)
      rx_done |=> !receive_ready_n)
      else $error("receive ready late");
   a_rx_ready_clear: assert property (@(posedge ref_clk) disable iff (!nrst)
      (rd_go && sync2_r.adr == 3'h0 && !dlab && !rx_done) |=> ##1 receive_ready_n)
      else $error("receive ready not released by data read");
   a_tx_start_time: assert property (@(posedge ref_clk) disable iff (!nrst)
      (tx_take && buf_out_valid) |-> ##[8:24] (tx_st_r == TX_SHIFT && !tx_line_r))
      else $error("start bit outside the allowed window");
   a_thre_clear: assert property (@(posedge ref_clk) disable iff (!nrst)
      (wr_go && sync2_r.adr == 3'h0 && !dlab && (buf_out_valid || thre_prev_r)) |=> !thre_int_r)
      else $error("data write did not clear empty interrupt");
   a_transmit_ready_n_full: assert property (@(posedge ref_clk) disable iff (!nrst)
      (!buf_in_ready && $rose(tx_st_r == TX_SHIFT)) |-> ##[0:8] transmit_ready_n)
      else $error("transmit ready not released after start");
   a_thre_flag: assert property (@(posedge ref_clk) disable iff (!nrst)
      buf_in_valid |=> !lsr_val[5])
      else $error("line status bit 5 set with data queued");

   c_rx_char: cover property (@(posedge ref_clk) disable iff (!nrst) rx_done ##1 irq_r);
   c_tx_frame: cover property (@(posedge ref_clk) disable iff (!nrst)
      (tx_st_r == TX_SHIFT && tx_bit_r == 4'h9));
   c_buf_full: cover property (@(posedge ref_clk) disable iff (!nrst) transmit_ready_n);
   c_scr_write: cover property (@(posedge ref_clk) disable iff (!nrst)
      (wr_go && sync2_r.adr == urset_pkg::ADR_SCR));
endmodule : urset_top

// ---- urset_pkg.sv ----
// constants, field layouts and carrier types of the serial port register bank
// Overview of operation
// - An 8-bit scratch register keeps whatever the host writes and reads it back unchanged.
// - Reset clears all eight interrupt enable bits.
// - Reset makes interrupt source read 0x01, meaning nothing is pending.
// - Reset clears line status bits 0-4 and 7 and sets bits 5-6.
// - Reset clears modem change bits 0-3 while bits 4-7 follow the modem pins.
// - The receive interrupt rises within one clock after the stop bit is sampled.
// - A transmit start bit begins 8 to 24 clocks after the write that clears the empty interrupt.
// - Receive ready goes low within one clock after the stop bit of a received character.
// - Transmit ready goes high within 8 clocks after a start bit begins when no room is left.
// - A host read that empties the receive holding location releases receive ready.
// - A host data write clears the empty interrupt, and a write that leaves room asserts ready; an empty-buffer write while sending releases it for one clock.
// - Line status bit 5 reads one whenever the transmit holding location is empty.
// - Outside loop-back, modem status bits 4-7 are the inverse of the modem input pins.
package urset_pkg;
   localparam logic [2:0] ADR_DATA  = 3'h0;
   localparam logic [2:0] ADR_IEN   = 3'h1;
   localparam logic [2:0] ADR_ISRC  = 3'h2;
   localparam logic [2:0] ADR_LCTL  = 3'h3;
   localparam logic [2:0] ADR_MCTL  = 3'h4;
   localparam logic [2:0] ADR_LSTAT = 3'h5;
   localparam logic [2:0] ADR_MSTAT = 3'h6;
   localparam logic [2:0] ADR_SCR   = 3'h7;

   localparam logic [7:0]  IEN_RST  = 8'h00;
   localparam logic [7:0]  LCTL_RST = 8'h00;
   localparam logic [7:0]  MCTL_RST = 8'h00;
   localparam logic [7:0]  QCTL_RST = 8'h00;
   localparam logic [7:0]  LSTAT_RST = 8'h60;
   localparam logic [15:0] DIV_RST  = 16'h0001;

   localparam int IEN_RX    = 0;
   localparam int IEN_THRE  = 1;
   localparam int IEN_LS    = 2;
   localparam int IEN_MS    = 3;
   localparam int LCTL_BRK  = 6;
   localparam int LCTL_DLAB = 7;
   localparam int MCTL_LOOP = 4;
   localparam int QCTL_RXRST = 1;
   localparam int QCTL_TXRST = 2;
   localparam int LSTAT_THRE = 5;

   localparam logic [7:0] ISRC_NONE = 8'h01;
   localparam logic [7:0] ISRC_LS   = 8'h06;
   localparam logic [7:0] ISRC_RX   = 8'h04;
   localparam logic [7:0] ISRC_THRE = 8'h02;
   localparam logic [7:0] ISRC_MS   = 8'h00;

   // event latencies are counted in receive-clock periods; ref_clk is that clock
   localparam int RCLK_PER_REF      = 1;
   localparam int TX_START_MIN_RCLK = 8;
   localparam int TX_START_MAX_RCLK = 24;
   localparam int TX_START_CYC      = TX_START_MIN_RCLK * RCLK_PER_REF;
   localparam int OVS_SHIFT         = 4;

   typedef struct packed {
      logic       cs_n;
      logic       rd_n;
      logic       wr_n;
      logic [2:0] adr;
      logic [7:0] dat;
      logic       sin;
      logic [3:0] mdm_n;
   } urset_pins_s;

   typedef struct packed {
      logic brk;
      logic frm;
      logic ovr;
   } urset_lserr_s;
endpackage : urset_pkg

// ---- urset_buf.sv ----
// two-entry valid/ready buffer in the transmit data path
`timescale 1ns/100ps
module urset_buf #(
   parameter int W     = 8,
   parameter int DEPTH = 2,
   parameter int AW    = $clog2(DEPTH)
)(
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic         flush,
   input  wire logic [W-1:0] in_data,
   input  wire logic         in_valid,
   output logic              in_ready,
   output logic [W-1:0]      out_data,
   output logic              out_valid,
   input  wire logic         out_ready
);
   logic [W-1:0]  mem_r   [DEPTH];
   logic [W-1:0]  mem_nxt [DEPTH];
   logic [AW-1:0] wp_r;
   logic [AW-1:0] wp_nxt;
   logic [AW-1:0] rp_r;
   logic [AW-1:0] rp_nxt;
   logic [AW:0]   cnt_r;
   logic [AW:0]   cnt_nxt;
   logic          push;
   logic          pop;

   assign in_ready  = (cnt_r != (AW+1)'(DEPTH));
   assign out_valid = (cnt_r != '0);
   assign out_data  = mem_r[rp_r];

   always_comb
   begin
      push    = in_valid && in_ready;
      pop     = out_valid && out_ready;
      mem_nxt = mem_r;
      wp_nxt  = wp_r;
      rp_nxt  = rp_r;
      if (push)
      begin
         mem_nxt[wp_r] = in_data;
         wp_nxt = (wp_r == AW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
      end
      if (pop)
         rp_nxt = (rp_r == AW'(DEPTH-1)) ? '0 : rp_r + 1'b1;
      cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
      if (flush)
      begin
         wp_nxt  = '0;
         rp_nxt  = '0;
         cnt_nxt = '0;
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wp_r  <= '0;
         rp_r  <= '0;
         cnt_r <= '0;
      end
      else
      begin
         wp_r  <= wp_nxt;
         rp_r  <= rp_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   // storage needs no reset; the count guards every read
   always_ff @(posedge clk)
   begin
      mem_r <= mem_nxt;
   end
endmodule : urset_buf

// ---- urset_peer.sv ----
// serial line peer that sends and collects 8N1 frames
`timescale 1ns/100ps
module urset_peer #(
   parameter int BITC = 16
)(
   input  wire logic ref_clk,
   input  wire logic line_rx,
   output logic      line_tx
);
   initial line_tx = 1'b1;

   task automatic send_byte(input logic [7:0] b);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++)
      begin
         @(posedge ref_clk);
         #1 line_tx = f[i];
         repeat (BITC - 1) @(posedge ref_clk);
      end
   endtask : send_byte

   // lat counts falling edges from the call until the start bit shows;
   // the line is looked at on falling edges, where it is settled
   task automatic recv_byte(output logic [7:0] b, output int lat);
      lat = 0;
      while (line_rx !== 1'b0 && lat < 300)
      begin
         @(negedge ref_clk);
         lat++;
      end
      repeat (BITC / 2) @(negedge ref_clk);
      for (int i = 0; i < 8; i++)
      begin
         repeat (BITC) @(negedge ref_clk);
         b[i] = line_rx;
      end
   endtask : recv_byte
endmodule : urset_peer

// ---- testbench.sv ----
// register bench for the serial port reset state and event timing
`timescale 1ns/100ps
module testbench;
   logic       ref_clk = 1'b0;
   logic       nrst = 1'b0;
   logic       host_select_n = 1'b1;
   logic [2:0] host_addr = 3'h0;
   logic       host_read_strobe_n = 1'b1;
   logic       host_write_strobe_n = 1'b1;
   logic [7:0] host_data_in = 8'h00;
   logic [7:0] host_data_out, q, got;
   logic       host_data_oe, serial_in, serial_out, dtr_n, rts_n, op1_n, op2_n, irq;
   logic       receive_ready_n, transmit_ready_n;
   logic [3:0] mdm_n = 4'hF;
   int         errors = 0;
   int         checks_done = 0;
   int         lat;

   always #20 ref_clk = ~ref_clk;

   urset_top i_urset_top (.ref_clk(ref_clk), .nrst(nrst), .host_select_n(host_select_n),
      .host_addr(host_addr), .host_read_strobe_n(host_read_strobe_n),
      .host_write_strobe_n(host_write_strobe_n), .host_data_in(host_data_in),
      .host_data_out(host_data_out), .host_data_oe(host_data_oe), .serial_in(serial_in),
      .serial_out(serial_out), .cts_n(mdm_n[0]), .dsr_n(mdm_n[1]), .ri_n(mdm_n[2]),
      .cd_n(mdm_n[3]), .dtr_n(dtr_n), .rts_n(rts_n), .op1_n(op1_n), .op2_n(op2_n),
      .irq(irq), .receive_ready_n(receive_ready_n), .transmit_ready_n(transmit_ready_n));

   urset_peer i_urset_peer (.ref_clk(ref_clk), .line_rx(serial_out), .line_tx(serial_in));

   task automatic check(input logic [7:0] g, input logic [7:0] e);
      checks_done++;
      if (g !== e)
      begin
         errors++;
         $display("CHECK FAILED at %0t got %h expected %h", $time, g, e);
      end
   endtask : check

   // strobe held long enough for the synchroniser, then released for 3 clocks
   task automatic access(input logic w, input logic [2:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      #1 host_select_n = 1'b0;
      host_addr = a;
      host_data_in = d;
      host_read_strobe_n = w;
      host_write_strobe_n = !w;
      repeat (5) @(posedge ref_clk);
      q = host_data_out;
      if (!w) check({7'h00, host_data_oe}, 8'h01);
      #1 host_select_n = 1'b1;
      host_read_strobe_n = 1'b1;
      host_write_strobe_n = 1'b1;
      repeat (3) @(posedge ref_clk);
   endtask : access

   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      access(1'b1, a, d);
   endtask : wr

   task automatic rd(input logic [2:0] a, input logic [7:0] e);
      access(1'b0, a, 8'h00);
      check(q, e);
   endtask : rd

   task automatic final_report;
      if (errors == 0 && checks_done > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : final_report

   initial
   begin
      #400000;
      errors++;
      final_report();
   end

   initial
   begin
      repeat (3) @(posedge ref_clk);
      #1 nrst = 1'b1;
      check({serial_out, dtr_n, rts_n, op1_n, op2_n, receive_ready_n, transmit_ready_n, irq},
         8'hFC);
      rd(urset_pkg::ADR_IEN, 8'h00);
      rd(urset_pkg::ADR_ISRC, 8'h01);
      rd(urset_pkg::ADR_LCTL, 8'h00);
      rd(urset_pkg::ADR_MCTL, 8'h00);
      rd(urset_pkg::ADR_LSTAT, 8'h60);
      rd(urset_pkg::ADR_MSTAT, 8'h00);
      #1 mdm_n = 4'b0110;
      rd(urset_pkg::ADR_MSTAT, 8'h99);
      rd(urset_pkg::ADR_MSTAT, 8'h90);
      foreach (got[i])
      begin
         wr(urset_pkg::ADR_SCR, 8'hA5 ^ (8'h01 << i));
         rd(urset_pkg::ADR_SCR, 8'hA5 ^ (8'h01 << i));
      end
      wr(urset_pkg::ADR_LCTL, 8'h03);
      rd(urset_pkg::ADR_LCTL, 8'h03);
      wr(urset_pkg::ADR_IEN, 8'h01);
      i_urset_peer.send_byte(8'hC3);
      check({6'h00, receive_ready_n, irq}, 8'h01);
      rd(urset_pkg::ADR_ISRC, 8'h04);
      rd(urset_pkg::ADR_DATA, 8'hC3);
      check({6'h00, receive_ready_n, irq}, 8'h02);
      fork
         begin
            wr(urset_pkg::ADR_DATA, 8'h3C);
            check({7'h00, transmit_ready_n}, 8'h00);
            rd(urset_pkg::ADR_LSTAT, 8'h20);
         end
         i_urset_peer.recv_byte(got, lat);
      join
      check(got, 8'h3C);
      // the write is taken 4 edges after the call; the start shows 9 edges later, at falling edge 14
      check({7'h00, lat >= 13 && lat <= 29}, 8'h01);
      wr(urset_pkg::ADR_DATA, 8'h5A);
      wr(urset_pkg::ADR_DATA, 8'hA5);
      check({7'h00, transmit_ready_n}, 8'h01);
      repeat (420) @(posedge ref_clk);
      rd(urset_pkg::ADR_LSTAT, 8'h60);
      final_report();
   end
endmodule : testbench
